// file: swp_pkg.sv
// Constants, opcodes and register map for the serial flash write-protect block
package swp_pkg;
   localparam int          CLK_MHZ      = 200;
   localparam int          PUW_NS       = 1000;
   localparam int          PUW_CYC      = (PUW_NS * CLK_MHZ + 999) / 1000;
   localparam logic [15:0] PUW_CNT      = 16'(PUW_CYC);
   localparam logic [11:0] CNT_MAX      = 12'hfff;
   localparam logic [11:0] HDR_BITS     = 12'h020;
   localparam logic [11:0] CMD_STATUS_WRITE_BITS    = 12'h010;
   localparam logic [11:0] PROG_BITS    = 12'h028;
   // Opcodes
   localparam logic [7:0]  OP_CMD_WRITE_ENABLE      = 8'h06;
   localparam logic [7:0]  OP_CMD_WRITE_DISABLE      = 8'h04;
   localparam logic [7:0]  OP_CMD_STATUS_WRITE      = 8'h01;
   localparam logic [7:0]  OP_PP        = 8'h02;
   localparam logic [7:0]  OP_QPP       = 8'h38;
   localparam logic [7:0]  OP_SE        = 8'h20;
   localparam logic [7:0]  OP_HBE       = 8'h52;
   localparam logic [7:0]  OP_BE        = 8'hd8;
   localparam logic [7:0]  OP_CE        = 8'hc7;
   localparam logic [7:0]  OP_CMD_SECURITY_WRITE    = 8'h2f;
   localparam logic [7:0]  OP_CMD_PROTECTION_SELECT     = 8'h68;
   localparam logic [7:0]  OP_DP        = 8'hb9;
   localparam logic [7:0]  OP_RDP       = 8'hab;
   localparam logic [7:0]  OP_RST       = 8'h99;
   localparam logic [7:0]  OP_SUSP      = 8'hb0;
   localparam logic [7:0]  OP_CMD_ENTER_SECURED_AREA      = 8'hb1;
   localparam logic [7:0]  OP_CMD_EXIT_SECURED_AREA      = 8'hc1;
   localparam logic [7:0]  OP_EQIO      = 8'h35;
   localparam logic [7:0]  OP_RSTQIO    = 8'hf5;
   // Register offsets
   localparam logic [3:0]  REG_STATUS   = 4'h0;
   localparam logic [3:0]  REG_SECUR    = 4'h1;
   localparam logic [3:0]  REG_MODE     = 4'h2;
   localparam logic [3:0]  REG_LASTOP   = 4'h3;
   localparam logic [3:0]  REG_CTRL     = 4'h4;
   localparam logic [3:0]  REG_REJECT   = 4'h5;
   // Status data byte fields and secured serial number end offset
   localparam int          ST_BP_LO     = 2;
   localparam int          ST_QE        = 6;
   localparam int          ST_SRWD      = 7;
   localparam logic [8:0]  OTP_ESN_END  = 9'h00f;
   // Operation kinds
   localparam logic [2:0]  K_PROG       = 3'h1;
   localparam logic [2:0]  K_SECTOR     = 3'h2;
   localparam logic [2:0]  K_HALF       = 3'h3;
   localparam logic [2:0]  K_BLOCK      = 3'h4;
   localparam logic [2:0]  K_CHIP       = 3'h5;
   // Reject reasons
   localparam logic [2:0]  RJ_NONE      = 3'h0;
   localparam logic [2:0]  RJ_LEN       = 3'h1;
   localparam logic [2:0]  RJ_DPD       = 3'h2;
   localparam logic [2:0]  RJ_WEL       = 3'h3;
   localparam logic [2:0]  RJ_PROT      = 3'h4;
   localparam logic [2:0]  RJ_HPM       = 3'h5;
   localparam logic [2:0]  RJ_INH       = 3'h6;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_FRAME = 3'b010,
      ST_EXEC  = 3'b100
   } swp_state_t;
endpackage

// file: swp_top.sv
// Command filter, write enable latch and block/OTP protection for a serial flash
`timescale 1ns/1ps
// Functional notes
// - After reset the command machine sits idle with nothing in progress.
// - Contents change only after a whole valid command frame has ended.
// - Frames that are empty or not byte aligned at chip select rise are dropped.
// - No program or erase until reset ends and the power-up delay expires.
// - Data-changing commands need the write enable latch set, else refused.
// - Latch clears on power-up, suspend, disable, status, program, erase, reset, security, select.
// - In deep power-down only release, signature read and soft reset act.
// - Block-protect bits make selected 64 KB blocks read-only.
// - Write-protect pin low with status write-protect set locks block-protect and status write-protect bits.
// - Pin protection is off in four-line or quad command mode.
// - Codes 1 to 6 protect top 1 to 32 blocks; 0 none.
// - Codes 9 to 14 protect bottom 32 to 63 blocks.
// - Codes 7, 8 and 15 protect all 64 blocks.
// - Secured area is programmed between enter and exit secured commands.
// - While secured mode is on the main array is not reachable.
// - Security bit 0 shows the factory lock.
// - Security write command sets customer lock bit 1.
// - A set lock clears only on reset and locked content never changes.
// - Secured offsets 000-00F are serial number, 010-1FF customer area.
module swp_top (
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   input  wire logic        sclk_i,
   input  wire logic        cs_n_i,
   input  wire logic [3:0]  sio_i,
   input  wire logic        busy_i,
   input  wire logic        factory_lock_i,
   input  wire logic [3:0]  addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [7:0]  rdata_o,
   output logic             op_start_o,
   output logic      [2:0]  op_kind_o,
   output logic      [23:0] op_addr_o,
   output logic             op_secured_o,
   output logic             suspend_o
);

   // Top codes guard blocks from 64-n up, bottom codes from 0 to n-1
   function automatic logic blk_prot(input logic [3:0] bp, input logic [5:0] blk);
      logic [6:0] n;
      n = 7'h00;
      if (bp == 4'h0) begin
         blk_prot = 1'b0;
      end else if (bp <= 4'h6) begin
         n = 7'(7'h01 << (bp - 4'h1));
         blk_prot = ({1'b0, blk} >= (7'h40 - n));
      end else if (bp >= 4'h9 && bp <= 4'he) begin
         n = 7'(7'h40 - (7'h40 >> (bp - 4'h8)));
         blk_prot = ({1'b0, blk} < n);
      end else begin
         blk_prot = 1'b1;
      end
   endfunction

   swp_pkg::swp_state_t state_q;
   logic        sclk_s1_q, sclk_s2_q, sclk_s3_q;
   logic        cs_s1_q, cs_s2_q, cs_s3_q;
   logic [3:0]  sio_s1_q, sio_s2_q;
   logic [11:0] cnt_q;
   logic [31:0] hdr_q;
   logic [15:0] puw_q;
   logic        wel_q;
   logic [3:0]  bp_q;
   logic        srwd_q;
   logic        qe_q;
   logic        quad_q;
   logic        dpd_q;
   logic        sotp_q;
   logic        clock_q;
   logic        flock_q;
   logic        swblk_q;
   logic [7:0]  lastop_q;
   logic [2:0]  rej_q;
   logic [7:0]  rdata_q;
   logic        start_q;
   logic [2:0]  kind_q;
   logic [23:0] oaddr_q;
   logic        osec_q;
   logic        susp_q;

   localparam logic [11:0] CNT_MAX  = swp_pkg::CNT_MAX;
   localparam logic [11:0] HDR_BITS = swp_pkg::HDR_BITS;
   localparam int          ST_BP_LO = swp_pkg::ST_BP_LO;
   localparam int          ST_SRWD  = swp_pkg::ST_SRWD;
   localparam int          ST_QE    = swp_pkg::ST_QE;

   // Link edges; first stages feed only the second stages
   wire         sclk_rise = sclk_s2_q & ~sclk_s3_q;
   wire         cs_rise   = cs_s2_q & ~cs_s3_q;
   wire         cs_low    = ~cs_s2_q;
   wire         wp_n      = sio_s2_q[2];
   wire [11:0]  step      = quad_q ? 12'h004 : 12'h001;
   wire [11:0]  cnt_inc   = (cnt_q > CNT_MAX - step) ? CNT_MAX : cnt_q + step;
   wire [5:0]   hdr_sh    = 6'(HDR_BITS - cnt_q);
   wire [31:0]  hdr_al    = (cnt_q >= HDR_BITS) ? hdr_q : (hdr_q << hdr_sh);
   wire [7:0]  op         = hdr_al[31:24];
   wire [23:0] adr        = hdr_al[23:0];
   wire [7:0]  sr_data    = hdr_al[23:16];
   wire [5:0]  blk        = adr[21:16];

   wire        frame_ok   = (cnt_q != 12'h000) && (cnt_q[2:0] == 3'h0);
   wire        dpd_blk    = dpd_q && (op != swp_pkg::OP_RDP) &&
                            (op != swp_pkg::OP_RST);
   wire        inhibit    = (puw_q != 16'h0000) || swblk_q || busy_i;
   wire        hpm_lock   = ~wp_n & srwd_q & ~qe_q & ~quad_q;
   wire        is_prog    = (op == swp_pkg::OP_PP) || (op == swp_pkg::OP_QPP);
   wire        is_erase   = (op == swp_pkg::OP_SE) || (op == swp_pkg::OP_HBE) ||
                            (op == swp_pkg::OP_BE) || (op == swp_pkg::OP_CE);
   wire        is_wrcmd   = is_prog || is_erase || (op == swp_pkg::OP_CMD_STATUS_WRITE) ||
                            (op == swp_pkg::OP_CMD_SECURITY_WRITE) || (op == swp_pkg::OP_CMD_PROTECTION_SELECT);
   wire        enough     = is_prog ? (cnt_q >= swp_pkg::PROG_BITS) :
                            (op == swp_pkg::OP_CMD_STATUS_WRITE) ? (cnt_q >= swp_pkg::CMD_STATUS_WRITE_BITS) :
                            ((is_erase && op != swp_pkg::OP_CE) ? (cnt_q >= HDR_BITS)
                                                                : 1'b1);
   // Serial region follows either lock, customer region only the customer lock
   wire        esn_area   = (adr[8:0] <= swp_pkg::OTP_ESN_END);
   wire        otp_locked = esn_area ? (flock_q | clock_q) : clock_q;
   wire        arr_prot   = (op == swp_pkg::OP_CE) ? (bp_q != 4'h0)
                                                   : blk_prot(bp_q, blk);
   wire        tgt_prot   = sotp_q ? (is_erase | otp_locked) : arr_prot;
   wire        do_exec    = (state_q == swp_pkg::ST_EXEC) && frame_ok && !dpd_blk;
   wire        wr_ok      = do_exec && is_wrcmd && enough && wel_q && !inhibit;
   wire        go_array   = wr_ok && (is_prog || is_erase) && !tgt_prot;
   wire        go_cmd_status_write    = wr_ok && (op == swp_pkg::OP_CMD_STATUS_WRITE) && !hpm_lock;
   wire [2:0]  kind       = (op == swp_pkg::OP_SE)  ? swp_pkg::K_SECTOR :
                            (op == swp_pkg::OP_HBE) ? swp_pkg::K_HALF :
                            (op == swp_pkg::OP_BE)  ? swp_pkg::K_BLOCK :
                            (op == swp_pkg::OP_CE)  ? swp_pkg::K_CHIP : swp_pkg::K_PROG;
   wire [2:0]  reject     = !frame_ok                    ? swp_pkg::RJ_LEN :
                            dpd_blk                      ? swp_pkg::RJ_DPD :
                            !is_wrcmd                    ? swp_pkg::RJ_NONE :
                            !enough                      ? swp_pkg::RJ_LEN :
                            !wel_q                       ? swp_pkg::RJ_WEL :
                            inhibit                      ? swp_pkg::RJ_INH :
                            ((is_prog || is_erase) && tgt_prot) ? swp_pkg::RJ_PROT :
                            ((op == swp_pkg::OP_CMD_STATUS_WRITE) && hpm_lock) ? swp_pkg::RJ_HPM :
                            swp_pkg::RJ_NONE;
   // Latch clears on the listed command completions, even when block protection refused them; a pin-locked status write keeps it
   wire        wel_clr    = (wr_ok && (op != swp_pkg::OP_CMD_STATUS_WRITE || go_cmd_status_write)) ||
                            (do_exec && ((op == swp_pkg::OP_CMD_WRITE_DISABLE) ||
                                         (op == swp_pkg::OP_RST) ||
                                         (op == swp_pkg::OP_SUSP && busy_i)));
   wire        wel_set    = do_exec && (op == swp_pkg::OP_CMD_WRITE_ENABLE);
   wire        go_susp    = do_exec && (op == swp_pkg::OP_SUSP) && busy_i;
   wire        go_rst     = do_exec && (op == swp_pkg::OP_RST);

   wire [7:0]  status_rd  = {srwd_q, qe_q, bp_q, wel_q, busy_i};
   wire [7:0]  rd_sel     = (addr_i == swp_pkg::REG_STATUS) ? status_rd :
                            (addr_i == swp_pkg::REG_SECUR)  ? {5'h00, sotp_q, clock_q, flock_q} :
                            (addr_i == swp_pkg::REG_MODE)   ?
                               {4'h0, hpm_lock, (puw_q != 16'h0000), dpd_q, quad_q} :
                            (addr_i == swp_pkg::REG_LASTOP) ? lastop_q :
                            (addr_i == swp_pkg::REG_CTRL)   ? {7'h00, swblk_q} :
                            (addr_i == swp_pkg::REG_REJECT) ? {5'h00, rej_q} : 8'h00;

   // Input synchronisers
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         sclk_s1_q <= 1'b0;
         sclk_s2_q <= 1'b0;
         sclk_s3_q <= 1'b0;
         cs_s1_q   <= 1'b1;
         cs_s2_q   <= 1'b1;
         cs_s3_q   <= 1'b1;
         sio_s1_q  <= 4'hf;
         sio_s2_q  <= 4'hf;
      end else begin
         sclk_s1_q <= sclk_i;
         sclk_s2_q <= sclk_s1_q;
         sclk_s3_q <= sclk_s2_q;
         cs_s1_q   <= cs_n_i;
         cs_s2_q   <= cs_s1_q;
         cs_s3_q   <= cs_s2_q;
         sio_s1_q  <= sio_i;
         sio_s2_q  <= sio_s1_q;
      end
   end

   // Frame collection: only the first 32 bits are kept
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         state_q <= swp_pkg::ST_IDLE;
         cnt_q   <= 12'h000;
         hdr_q   <= 32'h0000_0000;
      end else begin
         case (state_q)
            swp_pkg::ST_IDLE: begin
               cnt_q <= 12'h000;
               if (cs_low) begin
                  state_q <= swp_pkg::ST_FRAME;
               end
            end
            swp_pkg::ST_FRAME: begin
               if (cs_rise) begin
                  state_q <= swp_pkg::ST_EXEC;
               end else if (sclk_rise) begin
                  cnt_q <= cnt_inc;
                  if (cnt_q < HDR_BITS) begin
                     hdr_q <= quad_q ? {hdr_q[27:0], sio_s2_q} : {hdr_q[30:0], sio_s2_q[0]};
                  end
               end
            end
            swp_pkg::ST_EXEC: begin
               state_q <= swp_pkg::ST_IDLE;
            end
            default: begin
               state_q <= swp_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Power-up write inhibit timer
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         puw_q <= swp_pkg::PUW_CNT;
      end else if (puw_q != 16'h0000) begin
         puw_q <= puw_q - 16'h0001;
      end
   end

   // Write enable latch
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         wel_q <= 1'b0;
      end else if (wel_clr) begin
         wel_q <= 1'b0;
      end else if (wel_set) begin
         wel_q <= 1'b1;
      end
   end

   // Status bits and modes
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         bp_q   <= 4'h0;
         srwd_q <= 1'b0;
         qe_q   <= 1'b0;
         quad_q <= 1'b0;
         dpd_q  <= 1'b0;
         sotp_q <= 1'b0;
      end else begin
         if (go_cmd_status_write) begin
            bp_q   <= sr_data[ST_BP_LO +: 4];
            srwd_q <= sr_data[ST_SRWD];
            qe_q   <= sr_data[ST_QE];
         end
         if (go_rst) begin
            quad_q <= 1'b0;
            dpd_q  <= 1'b0;
            sotp_q <= 1'b0;
         end else if (do_exec) begin
            if (op == swp_pkg::OP_EQIO) quad_q <= 1'b1;
            if (op == swp_pkg::OP_RSTQIO) quad_q <= 1'b0;
            if (op == swp_pkg::OP_DP && !busy_i) dpd_q <= 1'b1;
            if (op == swp_pkg::OP_RDP) dpd_q <= 1'b0;
            if (op == swp_pkg::OP_CMD_ENTER_SECURED_AREA) sotp_q <= 1'b1;
            if (op == swp_pkg::OP_CMD_EXIT_SECURED_AREA) sotp_q <= 1'b0;
         end
      end
   end

   // Lock bits only set outside reset; the factory bit is sampled after release
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         clock_q <= 1'b0;
         flock_q <= 1'b0;
      end else begin
         if (factory_lock_i) flock_q <= 1'b1;
         if (wr_ok && op == swp_pkg::OP_CMD_SECURITY_WRITE) clock_q <= 1'b1;
      end
   end

   // Array controller request, one pulse per accepted operation
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         start_q <= 1'b0;
         kind_q  <= 3'h0;
         oaddr_q <= 24'h00_0000;
         osec_q  <= 1'b0;
         susp_q  <= 1'b0;
      end else begin
         start_q <= go_array;
         susp_q  <= go_susp;
         if (go_array) begin
            kind_q  <= kind;
            oaddr_q <= adr;
            osec_q  <= sotp_q;
         end
      end
   end

   // Register port; a read answers in the next cycle only
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rdata_q  <= 8'h00;
         swblk_q  <= 1'b0;
         lastop_q <= 8'h00;
         rej_q    <= swp_pkg::RJ_NONE;
      end else begin
         rdata_q <= rd_i ? rd_sel : 8'h00;
         if (wr_i && addr_i == swp_pkg::REG_CTRL) swblk_q <= wdata_i[0];
         if (state_q == swp_pkg::ST_EXEC) begin
            lastop_q <= op;
            rej_q    <= reject;
         end
      end
   end

   assign rdata_o      = rdata_q;
   assign op_start_o   = start_q;
   assign op_kind_o    = kind_q;
   assign op_addr_o    = oaddr_q;
   assign op_secured_o = osec_q;
   assign suspend_o    = susp_q;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   chk_reset_idle: assert property ($rose(nrst_i) |-> state_q == swp_pkg::ST_IDLE && !wel_q
                                    && puw_q == swp_pkg::PUW_CNT)
      else $error("not idle after reset");
   chk_puw_block: assert property ((puw_q != 16'h0000) |=> !op_start_o)
      else $error("operation during power-up delay");
   chk_len_drop: assert property ((state_q == swp_pkg::ST_EXEC && !frame_ok)
                                  |=> !op_start_o && $stable(wel_q) && $stable(bp_q))
      else $error("misaligned frame acted on");
   chk_wel_need: assert property ($rose(op_start_o) |-> $past(wel_q, 2))
      else $error("operation without latch");
   chk_wel_clear: assert property ((do_exec && op == swp_pkg::OP_CMD_WRITE_DISABLE) |=> !wel_q)
      else $error("latch not cleared");
   chk_dpd_filter: assert property ((state_q == swp_pkg::ST_EXEC && dpd_q
                                     && op == swp_pkg::OP_CMD_WRITE_ENABLE) |=> $stable(wel_q))
      else $error("command acted on in power-down");
   chk_blk_prot: assert property ((op_start_o && !op_secured_o && op_kind_o != swp_pkg::K_CHIP)
                                  |-> !blk_prot(bp_q, op_addr_o[21:16]))
      else $error("protected block programmed");
   chk_hpm_lock: assert property ((state_q == swp_pkg::ST_EXEC && hpm_lock)
                                  |=> $stable(bp_q) && $stable(srwd_q))
      else $error("locked status bits changed");
   chk_otp_lock: assert property (clock_q |=> clock_q [*4])
      else $error("customer lock cleared");
   chk_otp_noarr: assert property ((go_array && sotp_q) |=> op_secured_o)
      else $error("array reached in secured mode");

   // Latch, inhibit, power-down, pin-lock and secured-area guards
   chk_wel_start: assert property (op_start_o |-> !wel_q)
      else $error("latch left set after operation");
   chk_wel_susp: assert property (suspend_o |-> !wel_q)
      else $error("latch left set after suspend");
   chk_inh_start: assert property ((state_q == swp_pkg::ST_EXEC && inhibit)
                                   |=> !op_start_o && $stable(bp_q))
      else $error("write acted on while inhibited");
   chk_dpd_start: assert property ((state_q == swp_pkg::ST_EXEC && dpd_q)
                                   |=> !op_start_o)
      else $error("operation started in power-down");
   chk_otp_erase: assert property ((op_start_o && op_secured_o)
                                   |-> op_kind_o == swp_pkg::K_PROG)
      else $error("erase reached secured area");
   chk_flock_hold: assert property (flock_q |=> flock_q)
      else $error("factory lock cleared");
   chk_clock_wr: assert property ($rose(clock_q) |-> $past(wel_q))
      else $error("customer lock set without latch");
   chk_pin_ignore: assert property ((state_q == swp_pkg::ST_EXEC && hpm_lock
                                     && op == swp_pkg::OP_CMD_STATUS_WRITE) |=> $stable(qe_q))
      else $error("status write taken under pin lock");

endmodule // swp_top

// file: swp_host_model.sv
// Behavioural host-side serial controller driving the flash command pins
`timescale 1ns/1ps
module swp_host_model (
   input  wire logic       wp_n_i,
   output logic            sclk_o,
   output logic            cs_n_o,
   output logic      [3:0] sio_o
);
   logic d_q = 1'b0;
   logic t_q = 1'b0;
   logic clk_q = 1'b0;
   logic csn_q = 1'b1;
   // Unused lanes toggle so a stale level never reads as data
   assign sio_o = {t_q, wp_n_i, ~t_q, d_q};
   assign sclk_o = clk_q;
   assign cs_n_o = csn_q;
   // Mode 0, 80 ns clock that stands still between frames
   task automatic send(input logic [63:0] v, input int n);
      // Start off the system clock edge so no pin moves as it samples
      #1 csn_q = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         d_q = v[i];
         t_q = ~t_q;
         #40 clk_q = 1'b1;
         #40 clk_q = 1'b0;
      end
      #40 csn_q = 1'b1;
      d_q = ~d_q;
   endtask
endmodule // swp_host_model

// file: test_serial_flash_write_protect.sv
// Self-checking bench for the serial flash write-protect block
`timescale 1ns/1ps
module test_serial_flash_write_protect;
   logic        clk_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        busy_i = 1'b0;
   logic        factory_lock_i = 1'b0;
   logic [3:0]  addr_i = 4'h0;
   logic [7:0]  wdata_i = 8'h00;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic        wp_n = 1'b1;
   logic        sclk;
   logic        cs_n;
   logic [3:0]  sio;
   logic [7:0]  rdata_o;
   logic        op_start_o;
   logic [2:0]  op_kind_o;
   logic [23:0] op_addr_o;
   logic        op_secured_o;
   logic        suspend_o;
   int          n_fail = 0;
   int          num_checks = 0;
   int          n_ops = 0;
   int          n_susp = 0;
   logic [7:0]  ops [6] = '{swp_pkg::OP_PP, swp_pkg::OP_QPP, swp_pkg::OP_SE,
                            swp_pkg::OP_HBE, swp_pkg::OP_BE, swp_pkg::OP_CE};
   int          nb [6] = '{40, 40, 32, 32, 32, 8};
   logic [7:0]  clr [4] = '{swp_pkg::OP_CMD_WRITE_DISABLE, swp_pkg::OP_RST, swp_pkg::OP_CMD_PROTECTION_SELECT,
                            swp_pkg::OP_SUSP};

   initial forever #2.5 clk_i = ~clk_i;

   swp_host_model u_host (.wp_n_i(wp_n), .sclk_o(sclk), .cs_n_o(cs_n), .sio_o(sio));
   swp_top u_dut (
      .clk_i(clk_i), .nrst_i(nrst_i), .sclk_i(sclk), .cs_n_i(cs_n), .sio_i(sio),
      .busy_i(busy_i), .factory_lock_i(factory_lock_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .op_start_o(op_start_o), .op_kind_o(op_kind_o), .op_addr_o(op_addr_o),
      .op_secured_o(op_secured_o), .suspend_o(suspend_o));

   always @(posedge clk_i) begin
      if (op_start_o === 1'b1) n_ops++;
      if (suspend_o === 1'b1) n_susp++;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk(32'(rdata_o), 32'(exp));
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   // Frame then a settle gap longer than the sync and exec latency
   task automatic fr(input logic [63:0] v, input int n);
      u_host.send(v, n);
      repeat (12) @(posedge clk_i);
   endtask
   task automatic cmd_write_enable();
      fr(64'(swp_pkg::OP_CMD_WRITE_ENABLE), 8);
   endtask
   task automatic op_chk(input logic [63:0] v, input int n, input int exp);
      int b;
      b = n_ops;
      fr(v, n);
      chk(n_ops - b, exp);
   endtask
   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   function automatic int prot(input int c, input int b);
      if (c == 0) return 0;
      if (c <= 6) return int'(b >= 64 - (1 << (c - 1)));
      if (c >= 9 && c <= 14) return int'(b < 64 - (64 >> (c - 8)));
      return 1;
   endfunction
   function automatic int edg(input int c);
      if (c >= 1 && c <= 6) return 64 - (1 << (c - 1));
      if (c >= 9 && c <= 14) return 64 - (64 >> (c - 8));
      return 32;
   endfunction

   initial begin
      int b;
      repeat (2) @(posedge clk_i);
      nrst_i <= 1'b1;
      rd(swp_pkg::REG_STATUS, 8'h00);
      rd(swp_pkg::REG_MODE, 8'h04);
      rd(4'hf, 8'h00);
      repeat (200) @(posedge clk_i);
      rd(swp_pkg::REG_MODE, 8'h00);
      op_chk({swp_pkg::OP_PP, 24'h001000, 8'h11}, 40, 0);
      rd(swp_pkg::REG_REJECT, 8'h03);
      cmd_write_enable();
      op_chk({swp_pkg::OP_PP, 24'h001000, 7'h11}, 39, 0);
      rd(swp_pkg::REG_REJECT, 8'h01);
      op_chk(64'h020, 12, 0);
      rd(swp_pkg::REG_STATUS, 8'h02);
      wr(swp_pkg::REG_CTRL, 8'h01);
      wr(swp_pkg::REG_STATUS, 8'hff);
      rd(swp_pkg::REG_CTRL, 8'h01);
      op_chk({swp_pkg::OP_SE, 24'h0}, 32, 0);
      rd(swp_pkg::REG_REJECT, 8'h06);
      rd(swp_pkg::REG_STATUS, 8'h02);
      wr(swp_pkg::REG_CTRL, 8'h00);
      $display("test entry_checks done");
      for (int i = 0; i < 6; i++) begin
         if (i > 0) cmd_write_enable();
         rd(swp_pkg::REG_STATUS, 8'h02);
         op_chk(64'({ops[i], 24'h012345, 8'h5a}) >> (40 - nb[i]), nb[i], 1);
         chk(32'(op_kind_o), 32'((i < 2) ? 1 : i));
         if (nb[i] > 8) chk(32'(op_addr_o), 32'h012345);
         rd(swp_pkg::REG_STATUS, 8'h00);
      end
      fr(64'(swp_pkg::OP_DP), 8);
      rd(swp_pkg::REG_MODE, 8'h02);
      cmd_write_enable();
      rd(swp_pkg::REG_STATUS, 8'h00);
      rd(swp_pkg::REG_REJECT, 8'h02);
      fr(64'(swp_pkg::OP_RDP), 8);
      rd(swp_pkg::REG_MODE, 8'h00);
      $display("test ops_and_power_down done");
      for (int c = 0; c < 16; c++) begin
         cmd_write_enable();
         fr({swp_pkg::OP_CMD_STATUS_WRITE, 2'b00, 4'(c), 2'b00}, 16);
         rd(swp_pkg::REG_STATUS, {2'b00, 4'(c), 2'b00});
         for (int k = -1; k <= 0; k++) begin
            b = edg(c) + k;
            cmd_write_enable();
            op_chk({swp_pkg::OP_SE, 8'(b), 16'h0}, 32, 1 - prot(c, b));
            if (prot(c, b) == 1) rd(swp_pkg::REG_REJECT, 8'h04);
         end
      end
      $display("test block_protect done");
      cmd_write_enable();
      fr({swp_pkg::OP_CMD_STATUS_WRITE, 8'h80}, 16);
      wp_n <= 1'b0;
      cmd_write_enable();
      rd(swp_pkg::REG_MODE, 8'h08);
      fr({swp_pkg::OP_CMD_STATUS_WRITE, 8'h84}, 16);
      rd(swp_pkg::REG_STATUS, 8'h82);
      rd(swp_pkg::REG_REJECT, 8'h05);
      wp_n <= 1'b1;
      fr({swp_pkg::OP_CMD_STATUS_WRITE, 8'hc0}, 16);
      wp_n <= 1'b0;
      cmd_write_enable();
      rd(swp_pkg::REG_MODE, 8'h00);
      fr({swp_pkg::OP_CMD_STATUS_WRITE, 8'h00}, 16);
      rd(swp_pkg::REG_STATUS, 8'h00);
      wp_n <= 1'b1;
      $display("test pin_protect done");
      fr(64'(swp_pkg::OP_CMD_ENTER_SECURED_AREA), 8);
      rd(swp_pkg::REG_SECUR, 8'h04);
      factory_lock_i <= 1'b1;
      cmd_write_enable();
      op_chk({swp_pkg::OP_PP, 24'h000008, 8'h11}, 40, 0);
      rd(swp_pkg::REG_SECUR, 8'h05);
      cmd_write_enable();
      op_chk({swp_pkg::OP_PP, 24'h000010, 8'h11}, 40, 1);
      chk(32'(op_secured_o), 32'h1);
      cmd_write_enable();
      op_chk({swp_pkg::OP_SE, 24'h0}, 32, 0);
      cmd_write_enable();
      fr(64'(swp_pkg::OP_CMD_SECURITY_WRITE), 8);
      rd(swp_pkg::REG_SECUR, 8'h07);
      factory_lock_i <= 1'b0;
      cmd_write_enable();
      op_chk({swp_pkg::OP_PP, 24'h000020, 8'h11}, 40, 0);
      rd(swp_pkg::REG_SECUR, 8'h07);
      fr(64'(swp_pkg::OP_CMD_EXIT_SECURED_AREA), 8);
      cmd_write_enable();
      op_chk({swp_pkg::OP_PP, 24'h000020, 8'h11}, 40, 1);
      chk(32'(op_secured_o), 32'h0);
      $display("test secured_area done");
      for (int i = 0; i < 4; i++) begin
         cmd_write_enable();
         busy_i <= (clr[i] == swp_pkg::OP_SUSP);
         fr(64'(clr[i]), 8);
         rd(swp_pkg::REG_STATUS, {7'h00, busy_i});
         busy_i <= 1'b0;
      end
      chk(n_susp, 1);
      $display("test latch_clear done");
      cmd_write_enable();
      fr({swp_pkg::OP_CMD_STATUS_WRITE, 8'h80}, 16);
      wp_n <= 1'b0;
      fr(64'(swp_pkg::OP_EQIO), 8);
      rd(swp_pkg::REG_MODE, 8'h01);
      @(posedge clk_i);
      nrst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      nrst_i <= 1'b1;
      wp_n <= 1'b1;
      rd(swp_pkg::REG_MODE, 8'h04);
      rd(swp_pkg::REG_STATUS, 8'h00);
      rd(swp_pkg::REG_SECUR, 8'h00);
      $display("test quad_and_reset done");
      tally_and_finish();
   end

   // Whole run is about 200 us of link traffic
   initial begin
      #300us;
      n_fail++;
      $display("[ERR] t=%0t watchdog expired", $time);
      tally_and_finish();
   end
endmodule // test_serial_flash_write_protect
